//--- rtl/dsp_alu.sv
// dsp alu slice: multiply step, logic ops, address stack, reset opcode
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - a:b form one 64-bit unsigned register
// - one multiply step per opcode execution
// - a becomes (a + r*b0) shifted right
// - b shifts right, takes sum lsb
// - multiplicand r never changes in mult
// - nop changes nothing but the ops_done count
// - not inverts one accu, updates flags
// - or of distinct accus into first
// - pop shifts address stack, zero fill at bottom, no flags
// - five-step bit sequence triggers reset
// - 128-word pointer, pop restores previous
module dsp_alu
  import dsp_alu_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             por_pulse
);
  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_1, SEQ_2, SEQ_3, SEQ_4
  } seq_t;

  typedef struct packed {
    accus_t      ac;
    logic [3:0]  flags;
    logic        bit_lo;
    logic        bit_hi;
    seq_t        seq;
    logic        por;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        illegal;
    logic [7:0]  ops_done;
  } state_t;

  state_t s;
  state_t next_s;

  apb_req_t    req;
  instr_t      ins;
  logic        wr_acc;
  logic        rd_acc;
  logic [31:0] ma_out;
  logic [31:0] mb_out;
  logic [6:0]  rad_top;
  logic        stk_push;
  logic        stk_pop;
  logic [31:0] lres;
  logic [31:0] op1;
  logic [31:0] op2;

  assign req = '{psel, penable, pwrite, paddr, pwdata};
  assign wr_acc = req.psel && req.penable && req.pwrite && !s.ready;
  assign rd_acc = req.psel && req.penable && !req.pwrite && !s.ready;

  always_comb
  begin
    ins.valid = wr_acc && (req.paddr == OFF_CMD);
    ins.op    = opcode_t'(req.pwdata[CMD_OP_LSB +: 4]);
    ins.p1    = accu_sel_t'(req.pwdata[CMD_P1_LSB +: 2]);
    ins.p2    = accu_sel_t'(req.pwdata[CMD_P2_LSB +: 2]);
    ins.bitno = req.pwdata[CMD_BIT_LSB +: 6];
    ins.rad   = req.pwdata[CMD_RAD_LSB +: RAD_W];
  end

  mult_step u_mult
  (
    .a_in  (s.ac.a),
    .b_in  (s.ac.b),
    .r_in  (s.ac.r),
    .a_out (ma_out),
    .b_out (mb_out)
  );

  assign stk_push = ins.valid && (ins.op == OP_PUSH);
  assign stk_pop  = ins.valid && (ins.op == OP_POP);

  rad_stack #(.DEPTH(STACK_DEPTH)) u_stack
  (
    .pclk    (pclk),
    .presetn (presetn),
    .push    (stk_push),
    .pop     (stk_pop),
    .din     (ins.rad),
    .top     (rad_top)
  );

  function automatic accus_t accu_put(input accus_t ac, input accu_sel_t sel,
                                      input logic [31:0] v);
    accus_t o;
    o = ac;
    unique case (sel)
      SEL_A: o.a = v;
      SEL_B: o.b = v;
      SEL_R: o.r = v;
      default: o = ac;
    endcase
    return o;
  endfunction

  function automatic logic [3:0] logic_flags(input logic [31:0] v);
    logic [3:0] f;
    f = ZERO_FLAGS;
    f[FLAG_S] = v[31];
    f[FLAG_Z] = (v == ZERO_WORD);
    return f;
  endfunction

  assign op1 = accu_get(s.ac, ins.p1);
  assign op2 = accu_get(s.ac, ins.p2);
  assign lres = (ins.op == OP_NOT) ? ~op1 : (op1 | op2);

  always_comb
  begin
    next_s = s;
    next_s.ready = 1'b0;
    next_s.err = 1'b0;
    next_s.por = 1'b0;
    if (psel && penable && !s.ready)
    begin
      next_s.ready = 1'b1;
      next_s.rdata = ZERO_WORD;
    end
    if (ins.valid)
    begin
      next_s.ops_done = s.ops_done + 8'h01;
      unique case (ins.op)
        OP_NOP: ;
        OP_MULT:
        begin
          // r is not assigned here so it holds its value
          next_s.ac.a = ma_out;
          next_s.ac.b = mb_out;
        end
        OP_NOT:
        begin
          next_s.ac = accu_put(s.ac, ins.p1, lres);
          next_s.flags = logic_flags(lres);
        end
        OP_OR:
        begin
          if (ins.p1 == ins.p2)
          begin
            next_s.illegal = 1'b1;
            next_s.err = 1'b1;
          end
          else
          begin
            next_s.ac = accu_put(s.ac, ins.p1, lres);
            next_s.flags = logic_flags(lres);
          end
        end
        OP_POP: ;
        OP_PUSH: ;
        OP_BIT_CLEAR_OP, OP_BITS:
        begin
          if (ins.bitno == CTRL_BIT_LO)
            next_s.bit_lo = (ins.op == OP_BITS);
          if (ins.bitno == CTRL_BIT_HI)
            next_s.bit_hi = (ins.op == OP_BITS);
          next_s.seq = SEQ_IDLE;
          // five-step tracker for the reset sequence
          unique case (s.seq)
            SEQ_IDLE:
              if (ins.op == OP_BIT_CLEAR_OP && ins.bitno == CTRL_BIT_LO)
                next_s.seq = SEQ_1;
            SEQ_1:
              if (ins.op == OP_BIT_CLEAR_OP && ins.bitno == CTRL_BIT_HI)
                next_s.seq = SEQ_2;
            SEQ_2:
              if (ins.op == OP_BITS && ins.bitno == CTRL_BIT_HI)
                next_s.seq = SEQ_3;
            SEQ_3:
              if (ins.op == OP_BITS && ins.bitno == CTRL_BIT_LO)
                next_s.seq = SEQ_4;
            SEQ_4:
              if (ins.op == OP_BIT_CLEAR_OP && ins.bitno == CTRL_BIT_HI)
                next_s.por = 1'b1;
          endcase
          if (ins.op == OP_BIT_CLEAR_OP && ins.bitno == CTRL_BIT_LO
              && s.seq != SEQ_IDLE)
            next_s.seq = SEQ_1;
        end
        OP_LEGRST:
        begin
          // whole macro in one write; leaves bits as the sequence would
          next_s.bit_lo = 1'b1;
          next_s.bit_hi = 1'b0;
          next_s.seq = SEQ_IDLE;
          next_s.por = 1'b1;
        end
        default:
        begin
          next_s.illegal = 1'b1;
          next_s.err = 1'b1;
        end
      endcase
    end
    else if (wr_acc)
    begin
      unique case (req.paddr)
        OFF_A:     next_s.ac.a = req.pwdata;
        OFF_B:     next_s.ac.b = req.pwdata;
        OFF_R:     next_s.ac.r = req.pwdata;
        OFF_FLAGS: next_s.flags = req.pwdata[3:0];
        OFF_STAT:  next_s.illegal = 1'b0;
        default:   next_s.err = 1'b1;
      endcase
    end
    else if (rd_acc)
    begin
      unique case (req.paddr)
        OFF_CMD:   next_s.rdata = ZERO_WORD;
        OFF_A:     next_s.rdata = s.ac.a;
        OFF_B:     next_s.rdata = s.ac.b;
        OFF_R:     next_s.rdata = s.ac.r;
        OFF_FLAGS: next_s.rdata = {28'h000_0000, s.flags};
        OFF_RAD:   next_s.rdata = {25'h000_0000, rad_top};
        OFF_STAT:  next_s.rdata = {20'h0_0000, s.ops_done, 1'b0,
                                   s.illegal, s.bit_hi, s.bit_lo};
        default:   next_s.err = 1'b1;
      endcase
    end
    if (s.por)
    begin
      // device-wide reset request: clear accumulators and flags; address stack is kept
      next_s.ac = '0;
      next_s.flags = ZERO_FLAGS;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign prdata    = s.rdata;
  assign pready    = s.ready;
  assign pslverr   = s.err;
  assign por_pulse = s.por;

  property p_mult_r_kept;
    @(posedge pclk) disable iff (!presetn)
      (ins.valid && ins.op == OP_MULT && !s.por) |=> (s.ac.r == $past(s.ac.r));
  endproperty
  a_mult_r_kept: assert property (p_mult_r_kept)
    else $error("r changed by multiply step");

  property p_mult_a_top;
    @(posedge pclk) disable iff (!presetn)
      (ins.valid && ins.op == OP_MULT && !s.por) |=> (s.ac.a[31] == 1'b0);
  endproperty
  a_mult_a_top: assert property (p_mult_a_top)
    else $error("a msb not zero after multiply step");

  property p_mult_b_shift;
    @(posedge pclk) disable iff (!presetn)
      (ins.valid && ins.op == OP_MULT && !s.por)
        |=> (s.ac.b[30:0] == $past(s.ac.b[31:1]));
  endproperty
  a_mult_b_shift: assert property (p_mult_b_shift)
    else $error("b not shifted by multiply step");

  property p_mult_pair;
    @(posedge pclk) disable iff (!presetn)
      (ins.valid && ins.op == OP_MULT && !s.por)
        |=> ({s.ac.a, s.ac.b} ==
             {1'b0, 63'(({1'b0, $past(s.ac.a), $past(s.ac.b)} +
               ($past(s.ac.b[0]) ? {1'b0, $past(s.ac.r), 32'h0000_0000}
                                 : 65'h0)) >> 1)});
  endproperty
  a_mult_pair: assert property (p_mult_pair)
    else $error("a:b pair wrong after multiply step");

  property p_nop_still;
    @(posedge pclk) disable iff (!presetn)
      (ins.valid && ins.op == OP_NOP && !s.por)
        |=> (s.ac == $past(s.ac) && s.flags == $past(s.flags));
  endproperty
  a_nop_still: assert property (p_nop_still)
    else $error("nop changed state");

  property p_logic_flags;
    @(posedge pclk) disable iff (!presetn)
      (ins.valid && ins.op == OP_NOT && !s.por)
        |=> (!s.flags[FLAG_C] && !s.flags[FLAG_O]
             && s.flags[FLAG_Z] == (accu_get(s.ac, $past(ins.p1)) == 32'h0));
  endproperty
  a_logic_flags: assert property (p_logic_flags)
    else $error("logic op flags wrong");

  property p_or_same_kept;
    @(posedge pclk) disable iff (!presetn)
      (ins.valid && ins.op == OP_OR && ins.p1 == ins.p2 && !s.por)
        |=> (s.ac == $past(s.ac) && s.err);
  endproperty
  a_or_same_kept: assert property (p_or_same_kept)
    else $error("or with equal operands not refused");

  property p_pop_no_flags;
    @(posedge pclk) disable iff (!presetn)
      (stk_pop && !s.por) |=> (s.flags == $past(s.flags));
  endproperty
  a_pop_no_flags: assert property (p_pop_no_flags)
    else $error("pop touched flags");

  property p_por_one;
    @(posedge pclk) disable iff (!presetn)
      s.por |=> !s.por;
  endproperty
  a_por_one: assert property (p_por_one)
    else $error("reset pulse longer than one cycle");
endmodule
`default_nettype wire

//--- rtl/mult_step.sv
// one shift-and-add unsigned multiply step on the a:b pair
`timescale 1ns/1ns
`default_nettype none
module mult_step
  import dsp_alu_pkg::*;
(
  input  wire logic [31:0] a_in,
  input  wire logic [31:0] b_in,
  input  wire logic [31:0] r_in,
  output logic      [31:0] a_out,
  output logic      [31:0] b_out
);
  logic [32:0] sum;

  always_comb
  begin
    // carry out of the 32-bit sum is dropped: a[31] forced low
    sum = {1'b0, a_in} + (b_in[0] ? {1'b0, r_in} : 33'h0_0000_0000);
    a_out = sum[32:1];
    a_out[31] = 1'b0;
    b_out = {sum[0], b_in[31:1]};
  end
endmodule
`default_nettype wire

//--- rtl/rad_stack.sv
// ram address pointer stack with push and pop
`timescale 1ns/1ns
`default_nettype none
module rad_stack
  import dsp_alu_pkg::*;
#(
  parameter int unsigned DEPTH = STACK_DEPTH
)
(
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         push,
  input  wire logic         pop,
  input  wire logic [6:0]   din,
  output logic      [6:0]   top
);
  if (DEPTH < 2)
  begin
    $error("rad_stack depth must be at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][6:0] ent;
  } stk_t;

  stk_t st;
  stk_t next_st;

  always_comb
  begin
    next_st = st;
    if (push)
      next_st.ent = {st.ent[DEPTH-2:0], din};
    else if (pop)
      next_st.ent = {ZERO_RAD, st.ent[DEPTH-1:1]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign top = st.ent[0];
endmodule
`default_nettype wire

//--- shared/dsp_alu_pkg.sv
// shared constants, register map and types for the dsp alu block
package dsp_alu_pkg;

  localparam int unsigned DATA_W      = 32;
  localparam int unsigned RAD_W       = 7;
  localparam int unsigned STACK_DEPTH = 8;

  // apb register byte offsets
  localparam logic [7:0] OFF_CMD   = 8'h00;
  localparam logic [7:0] OFF_A     = 8'h04;
  localparam logic [7:0] OFF_B     = 8'h08;
  localparam logic [7:0] OFF_R     = 8'h0c;
  localparam logic [7:0] OFF_FLAGS = 8'h10;
  localparam logic [7:0] OFF_RAD   = 8'h14;
  localparam logic [7:0] OFF_STAT  = 8'h18;

  // command register fields
  localparam int unsigned CMD_OP_LSB = 0;
  localparam int unsigned CMD_P1_LSB = 4;
  localparam int unsigned CMD_P2_LSB = 6;
  localparam int unsigned CMD_BIT_LSB = 8;
  localparam int unsigned CMD_RAD_LSB = 16;

  // internal control bits driven by the bit ops
  localparam logic [5:0] CTRL_BIT_LO = 6'h36;
  localparam logic [5:0] CTRL_BIT_HI = 6'h37;

  // flag positions in the flag register
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_O = 1;
  localparam int unsigned FLAG_S = 2;
  localparam int unsigned FLAG_Z = 3;

  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam logic [3:0]  ZERO_FLAGS = 4'h0;
  localparam logic [6:0]  ZERO_RAD = 7'h00;

  typedef enum logic [3:0] {
    OP_NOP    = 4'h0,
    OP_MULT   = 4'h1,
    OP_NOT    = 4'h2,
    OP_OR     = 4'h3,
    OP_POP    = 4'h4,
    OP_BIT_CLEAR_OP   = 4'h5,
    OP_BITS   = 4'h6,
    OP_PUSH   = 4'h7,
    OP_LEGRST = 4'h8
  } opcode_t;

  typedef enum logic [1:0] {
    SEL_A = 2'h0,
    SEL_B = 2'h1,
    SEL_R = 2'h2
  } accu_sel_t;

  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] r;
  } accus_t;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic        valid;
    opcode_t     op;
    accu_sel_t   p1;
    accu_sel_t   p2;
    logic [5:0]  bitno;
    logic [6:0]  rad;
  } instr_t;

  function automatic logic [31:0] accu_get(input accus_t ac,
                                           input accu_sel_t s);
    logic [31:0] v;
    v = ac.a;
    if (s == SEL_B)
      v = ac.b;
    else if (s == SEL_R)
      v = ac.r;
    return v;
  endfunction

endpackage

//--- verif/tb_top.sv
// self-checking bench for the dsp alu slice
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import dsp_alu_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        por_pulse;
  int          n_fail;
  int          num_checks;
  int          cyc;
  int          n_por;
  int          k;
  logic [31:0] seed;
  logic [31:0] rd;
  logic        err;
  logic [31:0] e [3];
  logic [6:0]  q [3];
  logic [63:0] p;

  dsp_alu uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
               .prdata, .pready, .pslverr, .por_pulse);

  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // timeout ceiling sized well above the ~1000 cycles the tests need
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (por_pulse === 1'b1)
      n_por <= n_por + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      summarize();
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] cmd(input logic [3:0] op,
    input logic [1:0] p1, input logic [1:0] p2, input logic [5:0] bn,
    input logic [6:0] rv);
    return {9'h000, rv, 2'h0, bn, p2, p1, op};
  endfunction

  // 32-bit sum: the carry out of a is dropped, a[31] ends up zero
  function automatic logic [63:0] step(input logic [31:0] a,
    input logic [31:0] b, input logic [31:0] r);
    logic [31:0] s;
    s = a + (b[0] ? r : 32'h0000_0000);
    return {1'b0, s[31:1], s[0], b[31:1]};
  endfunction

  function automatic logic [31:0] lflags(input logic [31:0] v);
    return {28'h0000_000, v == 32'h0, v[31], 2'h0};
  endfunction

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] x,
    input logic [31:0] g);
    num_checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, x, g);
    end
  endtask

  // held from setup until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] ad,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] ad,
    input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(nm, x, rd);
  endtask

  task automatic chk3(input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] r);
    rdchk("a", OFF_A, a);
    rdchk("b", OFF_B, b);
    rdchk("r", OFF_R, r);
  endtask

  task automatic setacc(input logic [31:0] a, input logic [31:0] b,
    input logic [31:0] r);
    apb(1'b1, OFF_A, a);
    apb(1'b1, OFF_B, b);
    apb(1'b1, OFF_R, r);
  endtask

  // mask bit set selects the upper control bit for that step
  task automatic run_seq(input logic [4:0] hi);
    for (int i = 0; i < 5; i++)
      apb(1'b1, OFF_CMD, cmd((i == 2 || i == 3) ? OP_BITS : OP_BIT_CLEAR_OP,
          2'h0, 2'h0, hi[i] ? CTRL_BIT_HI : CTRL_BIT_LO, 7'h00));
  endtask

  initial
  begin
    seed = 32'hfa6a;
    n_fail = 0;
    num_checks = 0;
    cyc = 0;
    n_por = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    chk3(32'h0, 32'h0, 32'h0);
    rdchk("rad", OFF_RAD, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      e = '{rnd(), rnd(), rnd()};
      if (i == 0)
        e = '{32'hffff_ffff, 32'h0000_0001, 32'hffff_ffff};
      setacc(e[0], e[1], e[2]);
      apb(1'b1, OFF_CMD, cmd(OP_MULT, 2'h0, 2'h0, 6'h0, 7'h0));
      p = step(e[0], e[1], e[2]);
      chk3(p[63:32], p[31:0], e[2]);
    end
    e = '{32'h0, rnd(), rnd() & 32'h7fff_ffff};
    setacc(e[0], e[1], e[2]);
    for (int i = 0; i < 32; i++)
      apb(1'b1, OFF_CMD, cmd(OP_MULT, 2'h0, 2'h0, 6'h0, 7'h0));
    p = {32'h0, e[1]} * {32'h0, e[2]};
    chk3(p[63:32], p[31:0], e[2]);
    apb(1'b1, OFF_FLAGS, 32'h5);
    apb(1'b1, OFF_CMD, cmd(OP_NOP, 2'h0, 2'h0, 6'h0, 7'h0));
    chk3(p[63:32], p[31:0], e[2]);
    rdchk("flags", OFF_FLAGS, 32'h5);
    $display("mult and nop test done");
    for (int s = 0; s < 3; s++)
    begin
      e = '{rnd(), rnd(), rnd()};
      e[s] = (s == 0) ? 32'hffff_ffff : e[s];
      setacc(e[0], e[1], e[2]);
      apb(1'b1, OFF_FLAGS, 32'h3);
      apb(1'b1, OFF_CMD, cmd(OP_NOT, s[1:0], 2'h0, 6'h0, 7'h0));
      e[s] = ~e[s];
      chk3(e[0], e[1], e[2]);
      rdchk("not flags", OFF_FLAGS, lflags(e[s]));
    end
    $display("not test done");
    for (int i = 0; i < 9; i++)
    begin
      e = '{rnd(), rnd(), rnd()};
      e = (i == 1) ? '{32'h0, 32'h0, e[2]} : e;
      setacc(e[0], e[1], e[2]);
      apb(1'b1, OFF_FLAGS, 32'h3);
      apb(1'b1, OFF_CMD, cmd(OP_OR, 2'(i / 3), 2'(i % 3), 6'h0, 7'h0));
      chk("or err", {31'h0, i / 3 == i % 3}, {31'h0, err});
      k = (i / 3 == i % 3) ? 3 : 0;
      e[i / 3] = e[i / 3] | e[i % 3];
      chk3(e[0], e[1], e[2]);
      if (k == 0)
        rdchk("or flags", OFF_FLAGS, lflags(e[i / 3]));
      else
        rdchk("or flags", OFF_FLAGS, 32'h3);
    end
    apb(1'b0, OFF_STAT, 32'h0);
    chk("illegal", 32'h1, {31'h0, rd[2]});
    apb(1'b1, OFF_STAT, 32'h0);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("illegal clr", 32'h0, {31'h0, rd[2]});
    apb(1'b1, OFF_CMD, 32'h0000_0009);
    chk("bad op err", 32'h1, {31'h0, err});
    rdchk("cmd reads", OFF_CMD, 32'h0);
    $display("or test done");
    q = '{7'h7f, 7'(rnd()), 7'h40};
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, OFF_CMD, cmd(OP_PUSH, 2'h0, 2'h0, 6'h0, q[i]));
      rdchk("push top", OFF_RAD, {25'h0, q[i]});
    end
    apb(1'b1, OFF_FLAGS, 32'ha);
    for (int i = 2; i >= 0; i--)
    begin
      apb(1'b1, OFF_CMD, cmd(OP_POP, 2'h0, 2'h0, 6'h0, 7'h0));
      rdchk("pop top", OFF_RAD, i == 0 ? 32'h0 : {25'h0, q[i - 1]});
    end
    rdchk("pop flags", OFF_FLAGS, 32'ha);
    $display("stack test done");
    apb(1'b1, OFF_A, 32'h1234_5678);
    run_seq(5'b11010);
    repeat (4) @(posedge pclk);
    chk("por count", 32'h0, n_por);
    apb(1'b0, OFF_STAT, 32'h0);
    chk("ctrl bits", 32'h1, {30'h0, rd[1:0]});
    run_seq(5'b10110);
    for (int i = 0; i < 8 && n_por == 0; i++)
      @(posedge pclk);
    chk("por count", 32'h1, n_por);
    rdchk("a after por", OFF_A, 32'h0);
    apb(1'b1, OFF_CMD, cmd(OP_LEGRST, 2'h0, 2'h0, 6'h0, 7'h0));
    for (int i = 0; i < 8 && n_por == 1; i++)
      @(posedge pclk);
    chk("por count", 32'h2, n_por);
    $display("reset opcode test done");
    summarize();
  end
endmodule
`default_nettype wire
